//--- common/split_pkg.sv
// Overview of operation
// - Only downstream ports 3 and 4 split
// - Port 3 select 0x42 pin A, 0x05 B
// - Port 4 select 0x06 pin A, 0x04 B
// - Enable bit 5 port 3, bit 6 port 4
// - Port enable and global bit both required
// - Watch link-training state while split enabled
// - Stuck if dwelling in codes 0x4..0x9
// - Stuck link pulses power low, restarts timer
// - Timeout code maps to fixed periods
// - Timeout resets to 0x05, zero disables
// - Low time 350ms plus 10ms per step
// - Toggle time resets giving 400ms pulse
// - Toggle counter cleared after each toggle
// - Legacy power keeps driving USB 2.0 half
// - No overcurrent sensing on split output
`default_nettype none
package split_pkg;
  // Register indices, not byte offsets: each register sits at four times its index
  localparam logic [15:0] ADDR_PORT_EN = 16'h3c48;
  localparam logic [15:0] ADDR_GLOBAL_EN = 16'h4141;
  localparam logic [15:0] ADDR_P3_SEL = 16'h416e;
  localparam logic [15:0] ADDR_P4_SEL = 16'h416f;
  localparam logic [15:0] ADDR_TIMEOUT = 16'h4171;
  localparam logic [15:0] ADDR_TOGGLE = 16'h4176;
  localparam logic [15:0] ADDR_STATUS = 16'h4180;
  localparam logic [7:0] PORT_EN_RST = 8'h00;
  localparam logic [7:0] PORT_EN_MASK = 8'h60;
  localparam int P3_EN_BIT = 5;
  localparam int P4_EN_BIT = 6;
  localparam logic [7:0] GLOBAL_EN_RST = 8'h00;
  localparam logic [7:0] SEL_RST = 8'h00;
  localparam logic [7:0] P3_SEL_A = 8'h42;
  localparam logic [7:0] P3_SEL_B = 8'h05;
  localparam logic [7:0] P4_SEL_A = 8'h06;
  localparam logic [7:0] P4_SEL_B = 8'h04;
  localparam logic [7:0] TIMEOUT_RST = 8'h05;
  localparam logic [7:0] TOGGLE_RST = 8'h05;
  localparam logic [3:0] LINK_STUCK_LO = 4'h4;
  localparam logic [3:0] LINK_STUCK_HI = 4'h9;
  localparam int CLK_HZ = 10_000_000;
  localparam int TICK_MS = 1;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int TOGGLE_BASE_MS = 350;
  localparam int TOGGLE_STEP_MS = 10;
  localparam logic [15:0] TO_MS_1 = 16'd100;
  localparam logic [15:0] TO_MS_2 = 16'd250;
  localparam logic [15:0] TO_MS_3 = 16'd500;
  localparam logic [15:0] TO_MS_4 = 16'd750;
  localparam logic [15:0] TO_MS_5 = 16'd1000;
  localparam logic [15:0] TO_MS_6 = 16'd2000;
  typedef enum logic [1:0] {
    WD_IDLE = 2'b00,
    WD_WATCH = 2'b01,
    WD_TOGGLE = 2'b10
  } wd_state_t;
endpackage
`default_nettype wire

//--- hdl/ms_tick.sv
`timescale 1ns/100ps
`default_nettype none
module ms_tick #(
  parameter int CYCLES = 10000
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  output logic tick_out
);
  typedef struct packed {
    logic [15:0] cnt;
    logic tick;
  } tick_st_t;
  tick_st_t q;
  tick_st_t next_q;
  localparam logic [15:0] LAST = 16'(CYCLES - 1);
  // Divider wraps once per millisecond
  always_comb begin
    next_q = q;
    next_q.tick = (q.cnt == LAST);
    next_q.cnt = (q.cnt == LAST) ? 16'h0000 : q.cnt + 16'h0001;
  end
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end
  assign tick_out = q.tick;
endmodule // ms_tick
`default_nettype wire

//--- hdl/link_watchdog.sv
`timescale 1ns/100ps
`default_nettype none
module link_watchdog
  import split_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic tick_in,
  input wire logic enable_in,
  input wire logic [3:0] link_state_in,
  input wire logic [15:0] timeout_ms_in,
  input wire logic [15:0] toggle_ms_in,
  output logic power_on_out,
  output logic toggling_out
);
  typedef struct packed {
    wd_state_t st;
    logic [15:0] cnt;
    logic [3:0] last;
    logic pwr;
  } wd_st_t;
  wd_st_t q;
  wd_st_t next_q;
  logic stuck;
  assign stuck = (link_state_in >= LINK_STUCK_LO) && (link_state_in <= LINK_STUCK_HI);
  // Dwell timer, then low pulse; zero timeout never fires
  always_comb begin
    next_q = q;
    next_q.last = link_state_in;
    unique case (q.st)
      WD_IDLE: begin
        next_q.pwr = 1'b1;
        next_q.cnt = 16'h0000;
        if (enable_in && timeout_ms_in != 16'h0000) begin
          next_q.st = WD_WATCH;
        end
      end
      WD_WATCH: begin
        if (!enable_in || timeout_ms_in == 16'h0000) begin
          next_q.st = WD_IDLE;
        end else if (!stuck || link_state_in != q.last) begin
          next_q.cnt = 16'h0000;
        end else if (tick_in) begin
          if (q.cnt + 16'h0001 >= timeout_ms_in) begin
            next_q.st = WD_TOGGLE;
            next_q.pwr = 1'b0;
            next_q.cnt = 16'h0000;
          end else begin
            next_q.cnt = q.cnt + 16'h0001;
          end
        end
      end
      WD_TOGGLE: begin
        // Pulse runs to completion even if split is switched off
        if (tick_in) begin
          if (q.cnt + 16'h0001 >= toggle_ms_in) begin
            next_q.st = WD_WATCH;
            next_q.pwr = 1'b1;
            next_q.cnt = 16'h0000;
          end else begin
            next_q.cnt = q.cnt + 16'h0001;
          end
        end
      end
      default: begin
        next_q.st = WD_IDLE;
      end
    endcase
  end
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      q <= '{st: WD_IDLE, cnt: 16'h0000, last: 4'h0, pwr: 1'b1};
    end else begin
      q <= next_q;
    end
  end
  assign power_on_out = q.pwr;
  assign toggling_out = (q.st == WD_TOGGLE);
  a_low_only_toggle: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !q.pwr |-> q.st == WD_TOGGLE)
    else $error("split power low outside a toggle");
  a_nonstuck_clears: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (q.st == WD_WATCH && enable_in && timeout_ms_in != 16'h0000 && !stuck) |=> q.cnt == 16'h0000)
    else $error("timer not restarted on healthy state");
  a_toggle_ends_clear: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (q.st == WD_TOGGLE && $past(q.st) == WD_TOGGLE) ##1 (q.st == WD_WATCH) |-> q.cnt == 16'h0000)
    else $error("toggle counter not cleared");
  a_zero_disable: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (q.st != WD_TOGGLE && timeout_ms_in == 16'h0000) |=> q.pwr)
    else $error("toggle with timeout disabled");
endmodule // link_watchdog
`default_nettype wire

//--- hdl/port_split_link_recovery.sv
`timescale 1ns/100ps
`default_nettype none
module port_split_link_recovery
  import split_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYCLES
) (
  input wire logic SYS_CLK_IN,
  input wire logic RST_N_IN,
  input wire logic HSEL_IN,
  input wire logic [31:0] HADDR_IN,
  input wire logic [1:0] HTRANS_IN,
  input wire logic HWRITE_IN,
  input wire logic [2:0] HSIZE_IN,
  input wire logic [31:0] HWDATA_IN,
  input wire logic HREADY_IN,
  output logic [31:0] HRDATA_OUT,
  output logic HREADYOUT_OUT,
  output logic HRESP_OUT,
  input wire logic [3:0] P3_LINK_STATE_IN,
  input wire logic [3:0] P4_LINK_STATE_IN,
  input wire logic P3_LEGACY_POWER_IN,
  input wire logic P4_LEGACY_POWER_IN,
  output logic P3_LEGACY_POWER_CTL_OUT,
  output logic P4_LEGACY_POWER_CTL_OUT,
  output logic P3_ALT_PIN_A_OUT,
  output logic P3_ALT_PIN_B_OUT,
  output logic P4_ALT_PIN_A_OUT,
  output logic P4_ALT_PIN_B_OUT,
  output logic P3_ALT_PIN_A_OE_OUT,
  output logic P3_ALT_PIN_B_OE_OUT,
  output logic P4_ALT_PIN_A_OE_OUT,
  output logic P4_ALT_PIN_B_OE_OUT
);
  typedef struct packed {
    logic wr_pend;
    logic [15:0] wr_addr;
    logic [31:0] rdata;
    logic [7:0] port_en;
    logic [7:0] global_en;
    logic [7:0] p3_sel;
    logic [7:0] p4_sel;
    logic [7:0] timeout;
    logic [7:0] toggle;
    logic [3:0] p3_ls1;
    logic [3:0] p3_ls2;
    logic [3:0] p4_ls1;
    logic [3:0] p4_ls2;
    logic [3:0] pins;
    logic [3:0] oes;
    logic [1:0] leg;
  } top_st_t;
  top_st_t q;
  top_st_t next_q;
  logic tick;
  logic [1:0] split_on;
  logic [1:0] pwr_on;
  logic [1:0] toggling;
  logic [15:0] timeout_ms;
  logic [15:0] toggle_ms;
  logic addr_ok;
  logic [15:0] rd_addr;

  // Timeout code to milliseconds; reserved code reads as disabled
  function automatic logic [15:0] timeout_to_ms(input logic [2:0] code);
    unique case (code)
      3'h1: timeout_to_ms = TO_MS_1;
      3'h2: timeout_to_ms = TO_MS_2;
      3'h3: timeout_to_ms = TO_MS_3;
      3'h4: timeout_to_ms = TO_MS_4;
      3'h5: timeout_to_ms = TO_MS_5;
      3'h6: timeout_to_ms = TO_MS_6;
      default: timeout_to_ms = 16'h0000;
    endcase
  endfunction

  // Register read mux, used only by the bus read path
  function automatic logic [7:0] reg_read(input logic [15:0] a, input top_st_t s,
                                          input logic [1:0] tg);
    unique case (a)
      ADDR_PORT_EN: reg_read = s.port_en;
      ADDR_GLOBAL_EN: reg_read = s.global_en;
      ADDR_P3_SEL: reg_read = s.p3_sel;
      ADDR_P4_SEL: reg_read = s.p4_sel;
      ADDR_TIMEOUT: reg_read = s.timeout;
      ADDR_TOGGLE: reg_read = s.toggle;
      ADDR_STATUS: reg_read = {6'h00, tg};
      default: reg_read = 8'h00;
    endcase
  endfunction

  assign timeout_ms = timeout_to_ms(q.timeout[2:0]);
  assign toggle_ms = 16'(TOGGLE_BASE_MS) + 16'(TOGGLE_STEP_MS) * {8'h00, q.toggle};
  assign split_on[0] = q.port_en[P3_EN_BIT] & q.global_en[0];
  assign split_on[1] = q.port_en[P4_EN_BIT] & q.global_en[0];
  assign rd_addr = HADDR_IN[17:2]; // One aligned word per register index
  assign addr_ok = HSEL_IN && HREADY_IN && HTRANS_IN[1];

  ms_tick #(
    .CYCLES(TICK_CYC)
  ) u_tick (
    .clk_in(SYS_CLK_IN),
    .rst_n_in(RST_N_IN),
    .tick_out(tick)
  );

  // One watchdog each for the only two splittable ports
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_port
      link_watchdog u_wd (
        .clk_in(SYS_CLK_IN),
        .rst_n_in(RST_N_IN),
        .tick_in(tick),
        .enable_in(split_on[gi]),
        .link_state_in(gi == 0 ? q.p3_ls2 : q.p4_ls2),
        .timeout_ms_in(timeout_ms),
        .toggle_ms_in(toggle_ms),
        .power_on_out(pwr_on[gi]),
        .toggling_out(toggling[gi])
      );
    end
  endgenerate

  // Bus slave, pin routing and input synchronisers
  always_comb begin
    next_q = q;
    next_q.p3_ls1 = P3_LINK_STATE_IN;
    next_q.p3_ls2 = q.p3_ls1;
    next_q.p4_ls1 = P4_LINK_STATE_IN;
    next_q.p4_ls2 = q.p4_ls1;
    // Legacy control passes through one register stage unchanged; no overcurrent logic here
    next_q.leg = {P4_LEGACY_POWER_IN, P3_LEGACY_POWER_IN};
    // Data phase write
    if (q.wr_pend) begin
      unique case (q.wr_addr)
        ADDR_PORT_EN: next_q.port_en = HWDATA_IN[7:0] & PORT_EN_MASK;
        ADDR_GLOBAL_EN: next_q.global_en = {7'h00, HWDATA_IN[0]};
        ADDR_P3_SEL: next_q.p3_sel = HWDATA_IN[7:0];
        ADDR_P4_SEL: next_q.p4_sel = HWDATA_IN[7:0];
        ADDR_TIMEOUT: next_q.timeout = {5'h00, HWDATA_IN[2:0]};
        ADDR_TOGGLE: next_q.toggle = HWDATA_IN[7:0];
        default: next_q.wr_pend = 1'b0;
      endcase
    end
    next_q.wr_pend = 1'b0;
    // Address phase; read data is latched now so it stands in data phase
    if (addr_ok) begin
      next_q.wr_pend = HWRITE_IN;
      next_q.wr_addr = rd_addr;
      next_q.rdata = HWRITE_IN ? 32'h0000_0000 : {24'h000000, reg_read(rd_addr, q, toggling)};
    end
    // Split output steers to the selected alternate pin only
    next_q.pins = 4'hf;
    next_q.oes = 4'h0;
    if (split_on[0]) begin
      next_q.oes[0] = (q.p3_sel == P3_SEL_A);
      next_q.oes[1] = (q.p3_sel == P3_SEL_B);
      next_q.pins[1:0] = {2{pwr_on[0]}};
    end
    if (split_on[1]) begin
      next_q.oes[2] = (q.p4_sel == P4_SEL_A);
      next_q.oes[3] = (q.p4_sel == P4_SEL_B);
      next_q.pins[3:2] = {2{pwr_on[1]}};
    end
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      q <= '0;
      q.port_en <= PORT_EN_RST;
      q.global_en <= GLOBAL_EN_RST;
      q.p3_sel <= SEL_RST;
      q.p4_sel <= SEL_RST;
      q.timeout <= TIMEOUT_RST;
      q.toggle <= TOGGLE_RST;
      q.pins <= 4'hf;
    end else begin
      q <= next_q;
    end
  end

  assign HRDATA_OUT = q.rdata;
  assign HREADYOUT_OUT = 1'b1;
  assign HRESP_OUT = 1'b0;
  assign P3_LEGACY_POWER_CTL_OUT = q.leg[0];
  assign P4_LEGACY_POWER_CTL_OUT = q.leg[1];
  assign P3_ALT_PIN_A_OUT = q.pins[0];
  assign P3_ALT_PIN_B_OUT = q.pins[1];
  assign P4_ALT_PIN_A_OUT = q.pins[2];
  assign P4_ALT_PIN_B_OUT = q.pins[3];
  assign P3_ALT_PIN_A_OE_OUT = q.oes[0];
  assign P3_ALT_PIN_B_OE_OUT = q.oes[1];
  assign P4_ALT_PIN_A_OE_OUT = q.oes[2];
  assign P4_ALT_PIN_B_OE_OUT = q.oes[3];

  a_pin_a_select: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    (split_on[0] && q.p3_sel == P3_SEL_A) |=> P3_ALT_PIN_A_OE_OUT && !P3_ALT_PIN_B_OE_OUT)
    else $error("port 3 option A not routed");
  a_p4_select: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    (split_on[1] && q.p4_sel == P4_SEL_B) |=> P4_ALT_PIN_B_OE_OUT && !P4_ALT_PIN_A_OE_OUT)
    else $error("port 4 option B not routed");
  a_global_gate: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    !q.global_en[0] |=> q.oes == 4'h0)
    else $error("split pin driven with global disable");
  a_enable_bits: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    (q.port_en & ~PORT_EN_MASK) == 8'h00)
    else $error("reserved enable bit set");
  // Skip the first edge after reset, where the copy still holds its reset value
  a_legacy_pass: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    $past(RST_N_IN) |-> P3_LEGACY_POWER_CTL_OUT == $past(P3_LEGACY_POWER_IN))
    else $error("legacy power not passed");
  a_legacy_p4: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    $past(RST_N_IN) |-> P4_LEGACY_POWER_CTL_OUT == $past(P4_LEGACY_POWER_IN))
    else $error("port 4 legacy power not passed");
  a_p3_b_select: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    (split_on[0] && q.p3_sel == P3_SEL_B) |=> P3_ALT_PIN_B_OE_OUT && !P3_ALT_PIN_A_OE_OUT)
    else $error("port 3 option B not routed");
  a_p4_a_select: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    (split_on[1] && q.p4_sel == P4_SEL_A) |=> P4_ALT_PIN_A_OE_OUT && !P4_ALT_PIN_B_OE_OUT)
    else $error("port 4 option A not routed");
  a_p3_pulse_low: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    (split_on[0] && !pwr_on[0]) |=> !P3_ALT_PIN_A_OUT && !P3_ALT_PIN_B_OUT)
    else $error("port 3 split pin not pulled low");
  a_p4_pulse_low: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    (split_on[1] && !pwr_on[1]) |=> !P4_ALT_PIN_A_OUT && !P4_ALT_PIN_B_OUT)
    else $error("port 4 split pin not pulled low");
  a_timeout_short: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    (q.timeout[2:0] == 3'h1) |-> timeout_ms == 16'd100)
    else $error("timeout code 1 not 100 ms");
  a_timeout_long: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    (q.timeout[2:0] == 3'h6) |-> timeout_ms == 16'd2000)
    else $error("timeout code 6 not two seconds");
  a_timeout_off: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    (q.timeout[2:0] == 3'h0) |-> timeout_ms == 16'd0)
    else $error("zero timeout code not disabled");
  a_toggle_len: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    toggle_ms == 16'd350 + 16'd10 * {8'h00, q.toggle})
    else $error("toggle length wrong");
  a_timeout_map: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    (q.timeout[2:0] == 3'h5) |-> timeout_ms == 16'd1000)
    else $error("timeout code 5 not one second");
  a_read_back: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    (addr_ok && !HWRITE_IN && rd_addr == ADDR_TIMEOUT && !q.wr_pend) |=>
    HRDATA_OUT == {24'h000000, $past(q.timeout)})
    else $error("timeout readback wrong");
endmodule // port_split_link_recovery
`default_nettype wire

//--- bench/split_usb3_device.sv
`timescale 1ns/100ps
`default_nettype none
// Embedded USB 3.x device as the hub's link-training logic sees it
module split_usb3_device (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic power_in,
  input wire logic hold_in,
  input wire logic [3:0] code_in,
  output logic [3:0] link_state_out,
  output logic [7:0] falls_out,
  output logic [31:0] low_len_out
);
  logic [5:0] dwell;
  logic [31:0] run;
  logic power_d;
  // A busy link hops every 50 cycles; a dead one sits on one code
  always_ff @(posedge clk_in) begin
    power_d <= power_in;
    dwell <= (dwell == 6'd49) ? 6'd0 : dwell + 6'd1;
    if (!rst_n_in) begin
      link_state_out <= 4'h0;
      falls_out <= 8'h00;
      low_len_out <= 32'h0;
      run <= 32'h0;
      dwell <= 6'd0;
    end else begin
      if (hold_in)
        link_state_out <= code_in;
      else if (dwell == 6'd0)
        link_state_out <= (link_state_out inside {[4'h4:4'h8]}) ? link_state_out + 4'h1 : 4'h4;
      // Length of each power-off pulse, in clock cycles
      if (!power_in)
        run <= run + 32'h1;
      if (power_d && !power_in)
        falls_out <= falls_out + 8'h01;
      if (!power_d && power_in) begin
        low_len_out <= run;
        run <= 32'h0;
      end
    end
  end
endmodule // split_usb3_device
`default_nettype wire

//--- bench/port_split_link_recovery_tb.sv
`timescale 1ns/100ps
`default_nettype none
module port_split_link_recovery_tb;
  import split_pkg::*;
  // Short tick keeps second-long timeouts affordable in simulation
  localparam int T = 5;
  localparam int LIMIT = 90000;
  localparam logic [15:0] RA[8] = '{ADDR_PORT_EN, ADDR_GLOBAL_EN, ADDR_P3_SEL, ADDR_P4_SEL,
    ADDR_TIMEOUT, ADDR_TOGGLE, ADDR_STATUS, 16'h1234};
  localparam logic [7:0] RV[8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h05, 8'h05, 8'h00, 8'h00};
  localparam logic [7:0] FV[8] = '{8'h60, 8'h01, 8'hff, 8'hff, 8'h07, 8'hff, 8'h00, 8'h00};
  localparam int TO_MS[7] = '{0, 100, 250, 500, 750, 1000, 2000};
  localparam logic [7:0] TG[6] = '{8'h00, 8'h05, 8'h01, 8'h00, 8'hff, 8'h02};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [3:0] code3 = 4'h0;
  logic hold3 = 1'b1;
  logic leg3 = 1'b0, leg4 = 1'b0, leg3_d = 1'b0, leg4_d = 1'b0, rd_pend = 1'b0, chk_leg = 1'b0;
  logic [7:0] exp_q[$];
  logic [31:0] rng = 32'he2e7;
  int n_mismatch = 0, comparisons = 0, cyc = 0;
  wire logic [31:0] hrdata;
  wire logic [3:0] ls3, ls4;
  wire logic [7:0] f3, f4;
  wire logic [31:0] len3, len4;
  wire logic hready, hresp, l3, l4, a3, b3, a4, b4, ea3, eb3, ea4, eb4, p3_pwr, p4_pwr;
  // Split power pins have pull-ups: undriven reads as powered
  assign p3_pwr = ~((ea3 & ~a3) | (eb3 & ~b3));
  assign p4_pwr = ~((ea4 & ~a4) | (eb4 & ~b4));
  always #50 clk = ~clk;
  port_split_link_recovery #(.TICK_CYC(T)) dut (.SYS_CLK_IN(clk), .RST_N_IN(rst_n),
    .HSEL_IN(hsel), .HADDR_IN(haddr), .HTRANS_IN(htrans), .HWRITE_IN(hwrite),
    .HSIZE_IN(3'b010), .HWDATA_IN(hwdata), .HREADY_IN(hready), .HRDATA_OUT(hrdata),
    .HREADYOUT_OUT(hready), .HRESP_OUT(hresp), .P3_LINK_STATE_IN(ls3), .P4_LINK_STATE_IN(ls4),
    .P3_LEGACY_POWER_IN(leg3), .P4_LEGACY_POWER_IN(leg4), .P3_LEGACY_POWER_CTL_OUT(l3),
    .P4_LEGACY_POWER_CTL_OUT(l4), .P3_ALT_PIN_A_OUT(a3), .P3_ALT_PIN_B_OUT(b3),
    .P4_ALT_PIN_A_OUT(a4), .P4_ALT_PIN_B_OUT(b4), .P3_ALT_PIN_A_OE_OUT(ea3),
    .P3_ALT_PIN_B_OE_OUT(eb3), .P4_ALT_PIN_A_OE_OUT(ea4), .P4_ALT_PIN_B_OE_OUT(eb4));
  split_usb3_device u3 (.clk_in(clk), .rst_n_in(rst_n), .power_in(p3_pwr), .hold_in(hold3),
    .code_in(code3), .link_state_out(ls3), .falls_out(f3), .low_len_out(len3));
  split_usb3_device u4 (.clk_in(clk), .rst_n_in(rst_n), .power_in(p4_pwr), .hold_in(1'b1),
    .code_in(4'h0), .link_state_out(ls4), .falls_out(f4), .low_len_out(len4));
  function logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction
  function automatic logic ok(input int v, input int lo, input int hi);
    return v >= lo && v <= hi;
  endfunction
  task check(input logic [31:0] seen, input logic [31:0] want);
    comparisons++;
    if (seen !== want) begin
      n_mismatch++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task close_out();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // One single transfer; random upper bits must be ignored
  task automatic xfer(input logic w, input logic [15:0] a, input logic [7:0] d);
    logic [31:0] r;
    r = xs();
    hsel <= 1'b1;
    haddr <= {r[31:18], a, 2'b00};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= {r[23:0], d};
    do @(posedge clk); while (hready !== 1'b1);
  endtask
  task wr(input logic [15:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask
  task rd(input logic [15:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    xfer(1'b0, a, 8'h00);
  endtask
  task pins(input logic [3:0] e);
    repeat (2) @(posedge clk);
    // Look mid-cycle, once the registered pins have settled
    @(negedge clk);
    check({28'h0, ea3, eb3, ea4, eb4}, {28'h0, e});
    check({28'h0, a3, b3, a4, b4}, 32'hf);
    @(posedge clk);
  endtask
  task automatic wait_fall(input int bound, output int el);
    logic [7:0] f0;
    f0 = f3;
    el = 0;
    while (f3 === f0 && el < bound) begin
      @(posedge clk);
      el++;
    end
  endtask
  task automatic wait_rise(input int lo);
    int el;
    el = 0;
    while (p3_pwr !== 1'b1 && el < lo + 100) begin
      @(posedge clk);
      el++;
    end
    repeat (2) @(posedge clk);
  endtask
  task automatic quiet();
    logic [7:0] f0;
    f0 = f3;
    repeat (400 * T) @(posedge clk);
    check({24'h0, f3}, {24'h0, f0});
  endtask
  // Read data check against the oldest note, legacy power follow-through
  always @(posedge clk) begin
    if (rd_pend)
      check({24'h0, hrdata[7:0]}, {24'h0, exp_q.pop_front()});
    if (chk_leg)
      check({30'h0, l3, l4}, {30'h0, leg3_d, leg4_d});
    rd_pend <= hsel && htrans[1] && !hwrite && hready;
    leg3_d <= leg3;
    leg4_d <= leg4;
  end
  always @(posedge clk) begin
    {leg3, leg4} <= 2'(xs());
  end
  initial begin
    int el;
    int lo;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    chk_leg <= 1'b1;
    for (int i = 0; i < 8; i++)
      rd(RA[i], RV[i]);
    for (int i = 0; i < 8; i++) begin
      wr(RA[i], 8'hff);
      rd(RA[i], FV[i]);
    end
    wr(ADDR_P3_SEL, 8'h42);
    wr(ADDR_P4_SEL, 8'h04);
    pins(4'b1001);
    wr(ADDR_P3_SEL, 8'h05);
    wr(ADDR_P4_SEL, 8'h06);
    pins(4'b0110);
    wr(ADDR_PORT_EN, 8'h20);
    pins(4'b0100);
    wr(ADDR_GLOBAL_EN, 8'h00);
    pins(4'b0000);
    wr(ADDR_GLOBAL_EN, 8'h01);
    wr(ADDR_PORT_EN, 8'h60);
    wr(ADDR_P3_SEL, 8'h42);
    // Each stuck code with its own timeout code and a set pulse length
    for (int i = 0; i < 6; i++) begin
      wr(ADDR_TIMEOUT, 8'(i + 1));
      wr(ADDR_TOGGLE, TG[i]);
      code3 <= 4'(4 + i);
      wait_fall(TO_MS[i + 1] * T + 50, el);
      check({31'h0, ok(el, (TO_MS[i + 1] - 1) * T, TO_MS[i + 1] * T + 2 * T + 8)}, 32'h1);
      if (i == 0)
        rd(ADDR_STATUS, 8'h01);
      lo = (350 + 10 * TG[i]) * T;
      wait_rise(lo);
      check({31'h0, ok(len3, lo - T, lo + T + 4)}, 32'h1);
      if (i == 0) begin
        wait_fall(TO_MS[1] * T + 50, el);
        check({31'h0, ok(el, 98 * T, 102 * T + 8)}, 32'h1);
        wait_rise(lo);
        check({31'h0, ok(len3, lo - T, lo + T + 4)}, 32'h1);
      end
    end
    // Busy link, codes just outside the list, feature off
    wr(ADDR_TIMEOUT, 8'h01);
    hold3 <= 1'b0;
    quiet();
    hold3 <= 1'b1;
    code3 <= 4'h3;
    quiet();
    code3 <= 4'ha;
    quiet();
    wr(ADDR_PORT_EN, 8'h40);
    code3 <= 4'h7;
    quiet();
    wr(ADDR_PORT_EN, 8'h60);
    wr(ADDR_TIMEOUT, 8'h00);
    quiet();
    check({24'h0, f4}, 32'h0);
    close_out();
  end
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      n_mismatch++;
      close_out();
    end
  end
endmodule // port_split_link_recovery_tb
`default_nettype wire
